// ---- design/ppc_top.sv ----
// Port 4 and port 5 pin control with an Avalon-MM register slave
`timescale 1ns/1ps
`include "ppc_defines.svh"

module ppc_top
(
	input wire logic mclk_in,
	input wire logic rst_n_in,
	// Avalon-MM slave
	input wire logic [6:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Port 4 pads
	input wire logic [7:0] port4_pin_in,
	output logic [7:0] port4_pin_out,
	output logic [7:0] port4_pin_oe_out,
	output logic [7:0] port4_pull_up_out,
	output logic [7:0] port4_pull_down_out,
	output logic [7:0] port4_strong_out,
	// Port 5 pads
	input wire logic [7:0] port5_pin_in,
	output logic [7:0] port5_pin_out,
	output logic [7:0] port5_pin_oe_out,
	output logic [7:0] port5_pull_up_out,
	output logic [7:0] port5_pull_down_out,
	output logic [7:0] port5_strong_out,
	// Peripheral alternate outputs
	input wire logic [7:0] port4_alternate_one_in,
	input wire logic [7:0] port4_alternate_two_in,
	input wire logic [7:0] port4_alternate_three_in,
	input wire logic [7:0] port5_alternate_one_in,
	input wire logic [7:0] port5_alternate_two_in,
	input wire logic [7:0] port5_alternate_three_in,
	// Synchronised pin levels for peripheral inputs
	output logic [7:0] port4_periph_in_out,
	output logic [7:0] port5_periph_in_out,
	// External memory interface
	input wire logic emi_own_in,
	input wire logic [7:0] emi_data_wr_in,
	input wire logic emi_data_drive_in,
	input wire logic [7:0] emi_addr_in,
	output logic [7:0] emi_data_rd_out,
	// Port 3 register contents
	output logic [7:0] port3_output_select_high_out,
	output logic [7:0] port3_drive_strength_out
);

	// ********************************************************
	// State and helpers
	// ********************************************************
	ppc_pkg::ppc_state_t s_q; // Registered state
	ppc_pkg::ppc_state_t s_d; // Next state
	logic [7:0] w4_o; // Port 4 pin values
	logic [7:0] w4_oe; // Port 4 enables
	logic [7:0] w4_pu; // Port 4 pull-ups
	logic [7:0] w4_pd; // Port 4 pull-downs
	logic [7:0] w5_o; // Port 5 pin values
	logic [7:0] w5_oe; // Port 5 enables
	logic [7:0] w5_pu; // Port 5 pull-ups
	logic [7:0] w5_pd; // Port 5 pull-downs

	// Reset image of the register file
	localparam logic [17:0][7:0] REG_RST = {
		`PPC_RST_DS, `PPC_RST_SEL,
		`PPC_RST_DS, `PPC_RST_SEL, `PPC_RST_SEL, `PPC_RST_P5_PEN,
		`PPC_RST_PSEL, `PPC_RST_OD, `PPC_RST_DIR, `PPC_RST_LVL,
		`PPC_RST_DS, `PPC_RST_SEL, `PPC_RST_SEL, `PPC_RST_P4_PEN,
		`PPC_RST_PSEL, `PPC_RST_OD, `PPC_RST_DIR, `PPC_RST_LVL};

	// Word index of a byte address
	function automatic logic [4:0] reg_idx(input logic [6:0] a);
		reg_idx = a[6:2];
	endfunction

	// Address falls on a register
	function automatic logic reg_hit(input logic [6:0] a);
		reg_hit = (reg_idx(a) < `PPC_NREG);
	endfunction

	// Register of one port by offset
	function automatic logic [7:0] preg(input logic [17:0][7:0] r,
		input logic [4:0] base, input logic [4:0] off);
		logic [4:0] k;
		k = base + off;
		preg = r[k];
	endfunction

	// ********************************************************
	// Pin logic of both ports
	// ********************************************************
	// Port 4: data bus when the memory interface owns it
	ppc_pin_port
	#(
		.A1_MASK(`PPC_P4_A1),
		.A2_MASK(`PPC_P4_A2),
		.A3_MASK(`PPC_P4_A3)
	)
	u_port4
	(
		.level_in(preg(s_q.regs, `PPC_P4_BASE, `PPC_LVL)),
		.dir_in(preg(s_q.regs, `PPC_P4_BASE, `PPC_DIR)),
		.od_in(preg(s_q.regs, `PPC_P4_BASE, `PPC_OD)),
		.psel_in(preg(s_q.regs, `PPC_P4_BASE, `PPC_PSEL)),
		.pen_in(preg(s_q.regs, `PPC_P4_BASE, `PPC_PEN)),
		.slo_in(preg(s_q.regs, `PPC_P4_BASE, `PPC_SLO)),
		.shi_in(preg(s_q.regs, `PPC_P4_BASE, `PPC_SHI)),
		.alternate_one_in(port4_alternate_one_in),
		.alternate_two_in(port4_alternate_two_in),
		.alternate_three_in(port4_alternate_three_in),
		.emi_own_in(emi_own_in),
		.emi_val_in(emi_data_wr_in),
		.emi_drive_in(emi_data_drive_in),
		.pin_o_out(w4_o),
		.pin_oe_out(w4_oe),
		.pull_up_out(w4_pu),
		.pull_dn_out(w4_pd)
	);

	// Port 5: low address lines when owned
	ppc_pin_port
	#(
		.A1_MASK(`PPC_P5_A1),
		.A2_MASK(`PPC_P5_A2),
		.A3_MASK(`PPC_P5_A3)
	)
	u_port5
	(
		.level_in(preg(s_q.regs, `PPC_P5_BASE, `PPC_LVL)),
		.dir_in(preg(s_q.regs, `PPC_P5_BASE, `PPC_DIR)),
		.od_in(preg(s_q.regs, `PPC_P5_BASE, `PPC_OD)),
		.psel_in(preg(s_q.regs, `PPC_P5_BASE, `PPC_PSEL)),
		.pen_in(preg(s_q.regs, `PPC_P5_BASE, `PPC_PEN)),
		.slo_in(preg(s_q.regs, `PPC_P5_BASE, `PPC_SLO)),
		.shi_in(preg(s_q.regs, `PPC_P5_BASE, `PPC_SHI)),
		.alternate_one_in(port5_alternate_one_in),
		.alternate_two_in(port5_alternate_two_in),
		.alternate_three_in(port5_alternate_three_in),
		.emi_own_in(emi_own_in),
		.emi_val_in(emi_addr_in),
		.emi_drive_in(1'b1),
		.pin_o_out(w5_o),
		.pin_oe_out(w5_oe),
		.pull_up_out(w5_pu),
		.pull_dn_out(w5_pd)
	);

	// ********************************************************
	// Next state
	// ********************************************************
	always_comb
	begin
		logic [7:0] dir_p4;
		logic [7:0] dir_p5;
		logic [4:0] k4;
		logic [4:0] k5;
		dir_p4 = preg(s_q.regs, `PPC_P4_BASE, `PPC_DIR);
		dir_p5 = preg(s_q.regs, `PPC_P5_BASE, `PPC_DIR);
		k4 = `PPC_P4_BASE + `PPC_LVL;
		k5 = `PPC_P5_BASE + `PPC_LVL;
		s_d = s_q;
		// Two flip-flops on every pin input
		s_d.sync4a = port4_pin_in;
		s_d.sync4b = s_q.sync4a;
		s_d.sync5a = port5_pin_in;
		s_d.sync5b = s_q.sync5a;
		// Bus answer: one cycle of wait, then one acknowledge
		case (s_q.phase)
		ppc_pkg::PPC_IDLE:
		begin
			// Request taken, answer in the next cycle
			if (avs_read_in || avs_write_in)
			begin
				s_d.phase = ppc_pkg::PPC_ACK;
				s_d.wait_r = 1'b0;
				// Unmapped addresses read zero
				s_d.rdata = 32'h0;
				if (reg_hit(avs_address_in))
				begin
					s_d.rdata[7:0] = s_q.regs[reg_idx(avs_address_in)];
				end
			end
		end
		ppc_pkg::PPC_ACK:
		begin
			// Write lands at the edge that sees wait low
			s_d.phase = ppc_pkg::PPC_IDLE;
			s_d.wait_r = 1'b1;
			if (avs_write_in && avs_byteenable_in[0] && reg_hit(avs_address_in))
			begin
				s_d.regs[reg_idx(avs_address_in)] = avs_writedata_in[7:0];
			end
		end
		default:
		begin
			// Unknown phase falls back to idle
			s_d.phase = ppc_pkg::PPC_IDLE;
			s_d.wait_r = 1'b1;
		end
		endcase
		// Input pins update their data bits from the pad
		s_d.regs[k4] = (s_d.regs[k4] & dir_p4) | (s_q.sync4b & ~dir_p4);
		s_d.regs[k5] = (s_d.regs[k5] & dir_p5) | (s_q.sync5b & ~dir_p5);
		// Register pad controls so outputs come from flops
		s_d.p4_o = w4_o;
		s_d.p4_oe = w4_oe;
		s_d.p4_pu = w4_pu;
		s_d.p4_pd = w4_pd;
		s_d.p5_o = w5_o;
		s_d.p5_oe = w5_oe;
		s_d.p5_pu = w5_pu;
		s_d.p5_pd = w5_pd;
	end

	// ********************************************************
	// State register
	// ********************************************************
	always_ff @(posedge mclk_in)
	begin
		if (!rst_n_in)
		begin
			// Known value for every field
			s_q.phase <= ppc_pkg::PPC_IDLE;
			s_q.wait_r <= 1'b1;
			s_q.rdata <= 32'h0;
			s_q.regs <= REG_RST;
			s_q.sync4a <= 8'h00;
			s_q.sync4b <= 8'h00;
			s_q.sync5a <= 8'h00;
			s_q.sync5b <= 8'h00;
			s_q.p4_o <= 8'h00;
			s_q.p4_oe <= 8'h00;
			s_q.p4_pu <= 8'h00;
			s_q.p4_pd <= 8'h00;
			s_q.p5_o <= 8'h00;
			s_q.p5_oe <= 8'h00;
			s_q.p5_pu <= 8'h00;
			s_q.p5_pd <= 8'h00;
		end
		else
		begin
			// Registered copy of the next state
			s_q <= s_d;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	// Bus answer
	assign avs_readdata_out = s_q.rdata;
	assign avs_waitrequest_out = s_q.wait_r;
	// Port 4 pads
	assign port4_pin_out = s_q.p4_o;
	assign port4_pin_oe_out = s_q.p4_oe;
	assign port4_pull_up_out = s_q.p4_pu;
	assign port4_pull_down_out = s_q.p4_pd;
	assign port4_strong_out = s_q.regs[`PPC_P4_BASE + `PPC_DS];
	// Port 5 pads
	assign port5_pin_out = s_q.p5_o;
	assign port5_pin_oe_out = s_q.p5_oe;
	assign port5_pull_up_out = s_q.p5_pu;
	assign port5_pull_down_out = s_q.p5_pd;
	assign port5_strong_out = s_q.regs[`PPC_P5_BASE + `PPC_DS];
	// Synchronised pad levels
	assign port4_periph_in_out = s_q.sync4b;
	assign port5_periph_in_out = s_q.sync5b;
	assign emi_data_rd_out = s_q.sync4b;
	// Port 3 register contents
	assign port3_output_select_high_out = s_q.regs[`PPC_P3_SHI];
	assign port3_drive_strength_out = s_q.regs[`PPC_P3_STR];

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!rst_n_in);

	// Helper views of registers
	logic [7:0] lvl5; // Port 5 data bits
	logic [7:0] dir5; // Port 5 directions
	logic [7:0] od4; // Port 4 open-drain bits
	logic [7:0] od5; // Port 5 open-drain bits
	logic [7:0] sel5; // Port 5 pins with a nonzero select code
	assign lvl5 = s_q.regs[`PPC_P5_BASE + `PPC_LVL];
	assign dir5 = s_q.regs[`PPC_P5_BASE + `PPC_DIR];
	assign od4 = s_q.regs[`PPC_P4_BASE + `PPC_OD];
	assign od5 = s_q.regs[`PPC_P5_BASE + `PPC_OD];
	assign sel5 = s_q.regs[`PPC_P5_BASE + `PPC_SLO] | s_q.regs[`PPC_P5_BASE + `PPC_SHI];

	// Register file holds its reset image right after reset
	chk_reset_regs: assert property ($past(!rst_n_in) |->
		s_q.regs == REG_RST) else $error("register reset image wrong");

	// Bus answers one cycle after a request, for one cycle
	chk_bus_answer: assert property ((avs_read_in || avs_write_in) && s_q.wait_r
		|=> !avs_waitrequest_out ##1 avs_waitrequest_out) else $error("bus answer timing");

	// Open-drain pins never drive a high level
	chk_od_release: assert property ((od5 != 8'h00) |=>
		((port5_pin_oe_out & port5_pin_out & $past(od5)) == 8'h00))
		else $error("open drain drove high");

	// Input pins are never driven outside bus ownership
	chk_dir_input: assert property (!emi_own_in |=>
		((port5_pin_oe_out & ~$past(dir5)) == 8'h00)) else $error("input pin driven");

	// Input bits follow the synchronised pad
	chk_input_capture: assert property (!avs_write_in |=>
		(((lvl5 ^ $past(s_q.sync5b)) & ~$past(dir5)) == 8'h00))
		else $error("input data not captured");

	// Owned port 5 carries the address, open drain still applies
	chk_emi_addr: assert property (emi_own_in |=>
		port5_pin_out == $past(emi_addr_in) &&
		port5_pin_oe_out == ~($past(od5) & $past(emi_addr_in)))
		else $error("address lines wrong");

	// Owned port 4 carries the data lines, driven only when asked
	chk_emi_data: assert property (emi_own_in |=>
		port4_pin_out == $past(emi_data_wr_in) &&
		port4_pin_oe_out == ($past(emi_data_drive_in) ?
		~($past(od4) & $past(emi_data_wr_in)) : 8'h00))
		else $error("data lines wrong");

	// Code zero shows the data bit
	chk_gp_out: assert property (!emi_own_in && sel5 == 8'h00 |=>
		port5_pin_out == $past(lvl5)) else $error("general output wrong");

	// Unconnected first alternate on pin 0 shows the data bit
	chk_empty_slot: assert property (!emi_own_in &&
		s_q.regs[`PPC_P5_BASE + `PPC_SLO][0] && !s_q.regs[`PPC_P5_BASE + `PPC_SHI][0]
		|=> port5_pin_out[0] == $past(lvl5[0])) else $error("empty slot not data");

	// Pull-up follows enable and a set select bit
	chk_pull_sel: assert property (1'b1 |=>
		port4_pull_up_out == $past(s_q.regs[`PPC_P4_BASE + `PPC_PEN] &
		s_q.regs[`PPC_P4_BASE + `PPC_PSEL])) else $error("pull-up select wrong");

	// Pull-down follows enable and a clear select bit
	chk_pull_dn: assert property (1'b1 |=>
		port4_pull_down_out == $past(s_q.regs[`PPC_P4_BASE + `PPC_PEN] &
		~s_q.regs[`PPC_P4_BASE + `PPC_PSEL])) else $error("pull-down select wrong");

	// Main scenarios reached
	cov_write: cover property (avs_write_in && !avs_waitrequest_out);
	cov_read: cover property (avs_read_in && !avs_waitrequest_out);
	cov_emi: cover property (emi_own_in ##1 !emi_own_in);
	cov_od: cover property (od5 != 8'h00 && port5_pin_oe_out != 8'h00);
	cov_alt: cover property (!emi_own_in && sel5 != 8'h00);

endmodule

// ---- pkg/ppc_defines.svh ----
// Constants for the port 4 and port 5 pin control block
//
// Summary of operation
// - Ports four and five: eight configurable pins each
// - Pin data bit holds level, resets zero
// - Direction zero is input, one is output
// - Open-drain one drives low, releases high
// - Pull select zero pull-down, one pull-up
// - Pull enable one connects the selected device
// - Port4 pull enable 04, port5 pull enable ff
// - Select code from low,high bits picks function
// - Drive strength zero weak, one strong (reset)
// - Port3 and port5 select registers reset zero
// - Port4 carries external memory data bits
// - Port5 carries external memory low address bits
// - Alternates follow select registers; inputs see pin
`ifndef PPC_DEFINES_SVH
`define PPC_DEFINES_SVH

// ********************************************************
// Register map (word index, byte address is four times)
// ********************************************************
`define PPC_NREG 5'h12
`define PPC_P4_BASE 5'h00
`define PPC_P5_BASE 5'h08
`define PPC_LVL 5'h00
`define PPC_DIR 5'h01
`define PPC_OD 5'h02
`define PPC_PSEL 5'h03
`define PPC_PEN 5'h04
`define PPC_SLO 5'h05
`define PPC_SHI 5'h06
`define PPC_DS 5'h07
`define PPC_P3_SHI 5'h10
`define PPC_P3_STR 5'h11

// ********************************************************
// Reset values
// ********************************************************
`define PPC_RST_LVL 8'h00
`define PPC_RST_DIR 8'h00
`define PPC_RST_OD 8'h00
`define PPC_RST_PSEL 8'hff
`define PPC_RST_P4_PEN 8'h04
`define PPC_RST_P5_PEN 8'hff
`define PPC_RST_SEL 8'h00
`define PPC_RST_DS 8'hff

// ********************************************************
// Connected alternate output slots per pin
// ********************************************************
`define PPC_P4_A1 8'hfb
`define PPC_P4_A2 8'hfb
`define PPC_P4_A3 8'h02
`define PPC_P5_A1 8'hbc
`define PPC_P5_A2 8'h78
`define PPC_P5_A3 8'h60

`endif

// ---- pkg/ppc_pkg.sv ----
// Types shared by the pin control block
`include "ppc_defines.svh"
package ppc_pkg;

	// Bus answer phase
	typedef enum logic {PPC_IDLE, PPC_ACK} ppc_bus_t;

	// Whole state of the top module
	typedef struct packed {
		ppc_bus_t phase;
		logic wait_r;
		logic [31:0] rdata;
		logic [17:0][7:0] regs;
		logic [7:0] sync4a;
		logic [7:0] sync4b;
		logic [7:0] sync5a;
		logic [7:0] sync5b;
		logic [7:0] p4_o;
		logic [7:0] p4_oe;
		logic [7:0] p4_pu;
		logic [7:0] p4_pd;
		logic [7:0] p5_o;
		logic [7:0] p5_oe;
		logic [7:0] p5_pu;
		logic [7:0] p5_pd;
	} ppc_state_t;

endpackage

// ---- design/ppc_pin_port.sv ----
// Output selection and pad control for one eight-pin port
`timescale 1ns/1ps
`include "ppc_defines.svh"

module ppc_pin_port
#(
	parameter logic [7:0] A1_MASK = 8'hff,
	parameter logic [7:0] A2_MASK = 8'hff,
	parameter logic [7:0] A3_MASK = 8'hff
)
(
	input wire logic [7:0] level_in,
	input wire logic [7:0] dir_in,
	input wire logic [7:0] od_in,
	input wire logic [7:0] psel_in,
	input wire logic [7:0] pen_in,
	input wire logic [7:0] slo_in,
	input wire logic [7:0] shi_in,
	input wire logic [7:0] alternate_one_in,
	input wire logic [7:0] alternate_two_in,
	input wire logic [7:0] alternate_three_in,
	input wire logic emi_own_in,
	input wire logic [7:0] emi_val_in,
	input wire logic emi_drive_in,
	output logic [7:0] pin_o_out,
	output logic [7:0] pin_oe_out,
	output logic [7:0] pull_up_out,
	output logic [7:0] pull_dn_out
);

	// ********************************************************
	// Per-pin output value selection
	// ********************************************************
	// Code is {low select, high select}
	function automatic logic pick(input logic [1:0] code, input logic gp,
		input logic a1, input logic a2, input logic a3,
		input logic [2:0] have);
		case (code)
		2'b10: pick = have[0] ? a1 : gp;
		2'b01: pick = have[1] ? a2 : gp;
		2'b11: pick = have[2] ? a3 : gp;
		default: pick = gp;
		endcase
	endfunction

	// Value, enable and pulls for every pin
	always_comb
	begin
		for (int i = 0; i < 8; i++)
		begin
			logic v;
			logic en;
			v = 1'b0;
			en = 1'b0;
			if (emi_own_in)
			begin
				// External memory bus owns the pin
				v = emi_val_in[i];
				en = emi_drive_in;
			end
			else
			begin
				// Select registers steer the pin
				v = pick({slo_in[i], shi_in[i]}, level_in[i], alternate_one_in[i],
					alternate_two_in[i], alternate_three_in[i],
					{A3_MASK[i], A2_MASK[i], A1_MASK[i]});
				en = dir_in[i];
			end
			pin_o_out[i] = v;
			// Open drain releases a high level
			pin_oe_out[i] = en & ~(od_in[i] & v);
			pull_up_out[i] = pen_in[i] & psel_in[i];
			pull_dn_out[i] = pen_in[i] & ~psel_in[i];
		end
	end

endmodule

// ---- tb/ppc_pad_model.sv ----
// Model of the external pads seen by one eight-pin port
`timescale 1ns/1ps

module ppc_pad_model
(
	input wire logic clk_in,
	input wire logic [7:0] drv_in,
	input wire logic [7:0] oe_in,
	input wire logic [7:0] pu_in,
	input wire logic [7:0] pd_in,
	input wire logic [7:0] ext_val_in,
	input wire logic [7:0] ext_en_in,
	output logic [7:0] level_out
);
	// Undriven, unpulled pads wander every cycle
	logic [7:0] float_q = 8'h55;

	// Floating pattern
	always_ff @(posedge clk_in)
	begin
		float_q <= ~float_q;
	end

	// Pad wins: block drive, then board drive, then pull devices
	always_comb
	begin
		level_out = (oe_in & drv_in) | (~oe_in & ext_en_in & ext_val_in);
		level_out |= ~oe_in & ~ext_en_in & pu_in;
		level_out |= ~oe_in & ~ext_en_in & ~pu_in & ~pd_in & float_q;
	end
endmodule

// ---- tb/parallel_port_pin_control_test.sv ----
// Self-checking bench for the port 4 and port 5 pin control block
`timescale 1ns/1ps
`include "ppc_defines.svh"

module parallel_port_pin_control_test;
	// ********************************************************
	// Signals
	// ********************************************************
	logic mclk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic [6:0] adr = 7'h00;
	logic rd_en = 1'b0;
	logic wr_en = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [3:0] be = 4'h1;
	logic [31:0] rdat;
	logic wreq;
	logic [7:0] o4, o5, oe4, oe5, pu4, pu5, pd4, pd5, ds4, ds5, pi4, pi5, in4, in5;
	logic [7:0] pf4, pf5, erd, p3s, p3d;
	logic [7:0] a41 = 8'h00, a42 = 8'h00, a43 = 8'h00;
	logic [7:0] a5 [3] = '{8'h00, 8'h00, 8'h00};
	logic [7:0] x4v = 8'h00, x4e = 8'hff, x5v = 8'h00, x5e = 8'hff;
	logic own = 1'b0;
	logic edrv = 1'b0;
	logic [7:0] ewr = 8'h00, eadr = 8'h00;
	int n_mismatch = 0;
	int n_compared = 0;
	// Expected reset contents by word index
	logic [7:0] rst_tab [18] = '{8'h00, 8'h00, 8'h00, 8'hff, 8'h04, 8'h00, 8'h00, 8'hff,
		8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'hff};
	logic [7:0] amask [3] = '{`PPC_P5_A1, `PPC_P5_A2, `PPC_P5_A3};
	logic [1:0] code [3] = '{2'b10, 2'b01, 2'b11};

	ppc_top DUT
	(
		.mclk_in(mclk_in), .rst_n_in(rst_n_in), .avs_address_in(adr),
		.avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdat),
		.avs_byteenable_in(be), .avs_readdata_out(rdat), .avs_waitrequest_out(wreq),
		.port4_pin_in(in4), .port4_pin_out(o4), .port4_pin_oe_out(oe4),
		.port4_pull_up_out(pu4), .port4_pull_down_out(pd4), .port4_strong_out(ds4),
		.port5_pin_in(in5), .port5_pin_out(o5), .port5_pin_oe_out(oe5),
		.port5_pull_up_out(pu5), .port5_pull_down_out(pd5), .port5_strong_out(ds5),
		.port4_alternate_one_in(a41), .port4_alternate_two_in(a42),
		.port4_alternate_three_in(a43), .port5_alternate_one_in(a5[0]),
		.port5_alternate_two_in(a5[1]), .port5_alternate_three_in(a5[2]),
		.port4_periph_in_out(pf4), .port5_periph_in_out(pf5), .emi_own_in(own),
		.emi_data_wr_in(ewr), .emi_data_drive_in(edrv), .emi_addr_in(eadr),
		.emi_data_rd_out(erd), .port3_output_select_high_out(p3s),
		.port3_drive_strength_out(p3d)
	);

	// Board side of both ports
	ppc_pad_model pads4 (.clk_in(mclk_in), .drv_in(o4), .oe_in(oe4), .pu_in(pu4),
		.pd_in(pd4), .ext_val_in(x4v), .ext_en_in(x4e), .level_out(in4));
	ppc_pad_model pads5 (.clk_in(mclk_in), .drv_in(o5), .oe_in(oe5), .pu_in(pu5),
		.pd_in(pd5), .ext_val_in(x5v), .ext_en_in(x5e), .level_out(in5));

	// 25 MHz clock
	initial
	begin
		forever #20 mclk_in = ~mclk_in;
	end

	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic chk_rd(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t pins %h expected %h", $time, got, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is seen low
	task automatic bus(input logic w, input logic [4:0] idx, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge mclk_in);
		adr <= {idx, 2'b00};
		wdat <= {24'h0, d};
		wr_en <= w;
		rd_en <= ~w;
		// Only the watchdog ends a wait that never gets an answer
		do
		begin
			@(posedge mclk_in);
		end
		while (wreq !== 1'b0);
		q = rdat;
		wr_en <= 1'b0;
		rd_en <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] idx, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, idx, d, q);
	endtask

	task automatic rd_chk(input logic [4:0] idx, input logic [7:0] exp);
		logic [31:0] q;
		bus(1'b0, idx, 8'h00, q);
		chk_rd(q, {24'h0, exp});
	endtask

	// Let register changes and pad synchronisers land
	task automatic settle;
		repeat (4) @(posedge mclk_in);
	endtask

	task automatic done(input string s);
		$display("test %s finished", s);
	endtask

	task automatic report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// Watchdog
	initial
	begin
		repeat (5000) @(posedge mclk_in);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		report_and_stop();
	end

	// ********************************************************
	// Tests
	// ********************************************************
	initial
	begin
		repeat (16) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		for (int i = 0; i < 18; i++)
			rd_chk(i[4:0], rst_tab[i]);
		chk_pin(pu4, 8'h04);
		chk_pin(pu5, 8'hff);
		chk_pin(pd4, 8'h00);
		chk_pin(oe4 | oe5, 8'h00);
		chk_pin(ds4 & ds5, 8'hff);
		done("reset");
		// Unmapped word and disabled byte lane
		wr(5'h12, 8'hff);
		rd_chk(5'h12, 8'h00);
		be <= 4'h0;
		wr(5'h0f, 8'h00);
		be <= 4'h1;
		rd_chk(5'h0f, 8'hff);
		done("refused");
		// Port 5 push-pull then open-drain
		x5e <= 8'h00;
		wr(5'h09, 8'hff);
		wr(5'h08, 8'ha5);
		settle();
		chk_pin(oe5, 8'hff);
		chk_pin(o5, 8'ha5);
		rd_chk(5'h08, 8'ha5);
		wr(5'h0a, 8'hff);
		settle();
		chk_pin(oe5, 8'h5a);
		chk_pin(o5 & oe5, 8'h00);
		chk_pin(pf5, 8'ha5);
		wr(5'h0a, 8'h00);
		done("drive");
		// Pull device choice and enable
		wr(5'h0b, 8'h0f);
		wr(5'h0c, 8'h3c);
		settle();
		chk_pin(pu5, 8'h0c);
		chk_pin(pd5, 8'h30);
		done("pulls");
		// Port 4 input sampling
		x4v <= 8'h3c;
		settle();
		rd_chk(5'h00, 8'h3c);
		chk_pin(pf4, 8'h3c);
		done("input");
		// Every alternate code on port 5, level low
		a5 <= '{8'hf0, 8'h3c, 8'hff};
		wr(5'h08, 8'h00);
		for (int k = 0; k < 3; k++)
		begin
			wr(5'h0d, {8{code[k][1]}});
			wr(5'h0e, {8{code[k][0]}});
			settle();
			chk_pin(o5, amask[k] & a5[k]);
		end
		wr(5'h0d, 8'h00);
		wr(5'h0e, 8'h00);
		settle();
		chk_pin(o5, 8'h00);
		done("alternates");
		// Drive strength and port 3 registers
		wr(5'h0f, 8'h0f);
		wr(5'h11, 8'h5a);
		wr(5'h10, 8'hc3);
		settle();
		chk_pin(ds5, 8'h0f);
		chk_pin(p3d, 8'h5a);
		chk_pin(p3s, 8'hc3);
		done("strength");
		// External memory interface owns both ports
		own <= 1'b1;
		eadr <= 8'h69;
		ewr <= 8'hc3;
		edrv <= 1'b1;
		x4e <= 8'h00;
		settle();
		chk_pin(o5, 8'h69);
		chk_pin(oe5, 8'hff);
		chk_pin(o4, 8'hc3);
		chk_pin(oe4, 8'hff);
		edrv <= 1'b0;
		x4e <= 8'hff;
		x4v <= 8'h96;
		settle();
		chk_pin(oe4, 8'h00);
		chk_pin(erd, 8'h96);
		done("memory");
		report_and_stop();
	end
endmodule
